//--- core/desync_filter_defs.vh
// Constants for the per-channel transmit desync filter configuration block.
// Assumes inclusion by bare name from design files only.
`ifndef DESYNC_FILTER_DEFS_VH
`define DESYNC_FILTER_DEFS_VH

`define DF_NUM_CH        3
`define DF_ADDR_W        8
`define DF_OFS_CH0       8'h07
`define DF_OFS_CH1       8'h0F
`define DF_OFS_CH2       8'h17

`define DF_BIT_BW_LOW    0
`define DF_BIT_TX_PATH   1
`define DF_BIT_BW_HIGH   2
`define DF_BIT_RESET     3
`define DF_BIT_APS_DIS   4
`define DF_RW_MASK       5'h1F
`define DF_CTRL_RESET    5'h01

`define DF_BW_WIDE       2'h0
`define DF_BW_NARROW     2'h1
`define DF_BW_MEDIUM     2'h2
`define DF_BW_OTHER      2'h3

`define DF_MAX_GAP_BITS  59
`define DF_CLK_NS        8
`define DF_LINK_NS       160
// Cycles of the system clock per link bit, rounded down
`define DF_CYC_PER_BIT   (`DF_LINK_NS / `DF_CLK_NS)
// Gap detector limit: rise spacing after the longest legal gap, plus one
// bit of margin so synchroniser jitter never flags a legal gap
`define DF_GAP_LIMIT     ((`DF_MAX_GAP_BITS + 2) * `DF_CYC_PER_BIT)
`define DF_GAP_W         12

`endif

//--- core/desync_skid_buffer.v
// Two-entry valid/ready buffer for one channel's sampled data bits.
// Assumes a single clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module desync_skid_buffer (
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_sys_rst,
    // Fill side
    input  wire       i_in_valid,
    input  wire       i_in_data,
    output wire       o_in_ready,
    // Drain side
    output wire       o_out_valid,
    output wire       o_out_data,
    input  wire       i_out_ready
);
    reg  [1:0] mem_ff;
    reg        rd_ptr_ff;
    reg        wr_ptr_ff;
    reg  [1:0] count_ff;
    wire       push;
    wire       pop;

    assign o_in_ready  = (count_ff != 2'h2);
    assign o_out_valid = (count_ff != 2'h0);
    assign o_out_data  = mem_ff[rd_ptr_ff];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            mem_ff    <= 2'h0;
            rd_ptr_ff <= 1'b0;
            wr_ptr_ff <= 1'b0;
            count_ff  <= 2'h0;
        end else begin
            if (push) begin
                mem_ff[wr_ptr_ff] <= i_in_data;
                wr_ptr_ff         <= ~wr_ptr_ff;
            end
            if (pop)
                rd_ptr_ff <= ~rd_ptr_ff;
            if (push && !pop)
                count_ff <= count_ff + 2'h1;
            else if (pop && !push)
                count_ff <= count_ff - 2'h1;
        end
    end
endmodule
`default_nettype wire

//--- core/desync_filter_config.v
// Per-channel desync filter configuration: control registers, strap
// override, and gapped transmit clock/data capture for three channels.
// Assumes a plain register port on i_clk and asynchronous pins from the mapper.
`include "desync_filter_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module desync_filter_config (
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_sys_rst,
    // Register port
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output reg  [7:0] o_rdata,
    // Mode and straps
    input  wire       i_hw_mode,
    input  wire [2:0] i_bandwidth_select_low,
    input  wire [2:0] i_bandwidth_select_high,
    input  wire [2:0] i_attenuator_path_select,
    // Mapper link
    input  wire [2:0] i_tx_clock_in,
    input  wire [2:0] i_tx_data_in,
    // Captured stream
    output reg  [2:0] o_bit_valid,
    output reg  [2:0] o_bit_data,
    input  wire [2:0] i_bit_ready,
    // Effective configuration and health flags
    output reg  [5:0] o_bandwidth,
    output reg  [2:0] o_attenuator_in_transmit_path,
    output reg  [2:0] o_fast_recovery_en,
    output reg  [2:0] o_filter_reset,
    output reg  [2:0] o_gap_overrun,
    output reg  [2:0] o_overflow
);
    ////////////////////////////////////////////////////////////////////////
    // Address decode
    function [1:0] ch_of;
        input [7:0] addr;
        begin
            case (addr)
                `DF_OFS_CH0: ch_of = 2'h0;
                `DF_OFS_CH1: ch_of = 2'h1;
                `DF_OFS_CH2: ch_of = 2'h2;
                default:     ch_of = 2'h3;
            endcase
        end
    endfunction

    function [1:0] bw_code;
        input lo;
        input hi;
        begin
            // narrow when low set and high clear
            case ({hi, lo})
                2'b01:   bw_code = `DF_BW_NARROW;
                2'b10:   bw_code = `DF_BW_MEDIUM;
                2'b11:   bw_code = `DF_BW_OTHER;
                default: bw_code = `DF_BW_WIDE;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Control registers and read port
    // Channel g owns bits 5g+4..5g, so the bank has a single writer
    reg  [14:0] ctrl_ff;
    wire [14:0] nxt_ctrl;
    wire [1:0]  wr_ch = ch_of(i_addr);
    reg  [7:0]  nxt_rdata;

    always @* begin
        nxt_rdata = 8'h00;
        // bits 7..5 read as zero, unmapped reads zero
        if (i_rd) begin
            case (wr_ch)
                2'h0:    nxt_rdata = {3'h0, ctrl_ff[4:0]};
                2'h1:    nxt_rdata = {3'h0, ctrl_ff[9:5]};
                2'h2:    nxt_rdata = {3'h0, ctrl_ff[14:10]};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
            ctrl_ff <= {`DF_NUM_CH{`DF_CTRL_RESET}};
        end else begin
            o_rdata <= nxt_rdata;
            ctrl_ff <= nxt_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hardware mode synchronizer, shared by all channels
    reg [1:0] hw_sync_ff;
    always @(posedge i_clk) begin
        if (i_sys_rst)
            hw_sync_ff <= 2'h0;
        else
            hw_sync_ff <= {hw_sync_ff[0], i_hw_mode};
    end
    wire hw_mode = hw_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // Per-channel next values, gathered so every output has one flop
    localparam [`DF_GAP_W-1:0] GAP_LIMIT = `DF_GAP_LIMIT;

    wire [2:0]             nxt_bit_valid;
    wire [2:0]             nxt_bit_data;
    wire [5:0]             nxt_bandwidth;
    wire [2:0]             nxt_path;
    wire [2:0]             nxt_fast_recovery;
    wire [2:0]             nxt_filter_reset;
    wire [2:0]             nxt_gap_overrun;
    wire [2:0]             nxt_overflow;
    wire [3*`DF_GAP_W-1:0] nxt_gap_cnt;
    reg  [3*`DF_GAP_W-1:0] gap_cnt_ff;

    genvar g;
    generate
        for (g = 0; g < `DF_NUM_CH; g = g + 1) begin : chan
            localparam [1:0] CH = g;

            reg  [1:0]           lo_sync_ff;
            reg  [1:0]           hi_sync_ff;
            reg  [1:0]           ps_sync_ff;
            reg  [2:0]           clk_sync_ff;
            reg  [1:0]           dat_sync_ff;
            reg                  nxt_valid;
            reg                  nxt_data;
            reg                  nxt_gap;
            reg  [`DF_GAP_W-1:0] nxt_cnt;
            wire [4:0]           ctrl;
            wire [`DF_GAP_W-1:0] gap_cnt;
            wire                 clk_rise;
            wire                 take_bit;
            wire                 buf_in_ready;
            wire                 buf_valid;
            wire                 buf_data;
            wire                 eff_lo;
            wire                 eff_hi;
            wire                 eff_path;

            assign ctrl    = ctrl_ff[5*g+4:5*g];
            assign gap_cnt = gap_cnt_ff[`DF_GAP_W*g+`DF_GAP_W-1:`DF_GAP_W*g];

            assign nxt_ctrl[5*g+4:5*g] = (i_wr && wr_ch == CH) ? (i_wdata[4:0] & `DF_RW_MASK) : ctrl;

            always @(posedge i_clk) begin
                if (i_sys_rst) begin
                    lo_sync_ff  <= 2'h0;
                    hi_sync_ff  <= 2'h0;
                    ps_sync_ff  <= 2'h0;
                    clk_sync_ff <= 3'h0;
                    dat_sync_ff <= 2'h0;
                end else begin
                    lo_sync_ff  <= {lo_sync_ff[0], i_bandwidth_select_low[g]};
                    hi_sync_ff  <= {hi_sync_ff[0], i_bandwidth_select_high[g]};
                    ps_sync_ff  <= {ps_sync_ff[0], i_attenuator_path_select[g]};
                    clk_sync_ff <= {clk_sync_ff[1:0], i_tx_clock_in[g]};
                    dat_sync_ff <= {dat_sync_ff[0], i_tx_data_in[g]};
                end
            end

            // straps replace register fields in hardware mode
            assign eff_lo   = hw_mode ? lo_sync_ff[1] : ctrl[`DF_BIT_BW_LOW];
            assign eff_hi   = hw_mode ? hi_sync_ff[1] : ctrl[`DF_BIT_BW_HIGH];
            assign eff_path = hw_mode ? ps_sync_ff[1] : ctrl[`DF_BIT_TX_PATH];

            // rising edge of gapped clock, data aligned in same delay
            assign clk_rise = clk_sync_ff[1] & ~clk_sync_ff[2];
            // Bits seen while the filter sits in the receive path are dropped
            assign take_bit = clk_rise & eff_path;

            desync_skid_buffer u_buf (
                .i_clk       (i_clk),
                .i_sys_rst   (i_sys_rst),
                .i_in_valid  (take_bit),
                .i_in_data   (dat_sync_ff[1]),
                .o_in_ready  (buf_in_ready),
                .o_out_valid (buf_valid),
                .o_out_data  (buf_data),
                .i_out_ready (~o_bit_valid[g])
            );

            // Output stage loads whenever empty, so valid never waits on ready
            always @* begin
                nxt_valid = o_bit_valid[g];
                nxt_data  = o_bit_data[g];
                if (o_bit_valid[g]) begin
                    if (i_bit_ready[g])
                        nxt_valid = 1'b0;
                end else if (buf_valid) begin
                    nxt_valid = 1'b1;
                    nxt_data  = buf_data;
                end
            end

            // gaps up to 59 bits are normal; only gaps over 60 bits are flagged, one bit of margin
            always @* begin
                nxt_cnt = gap_cnt;
                nxt_gap = o_gap_overrun[g];
                if (clk_rise) begin
                    nxt_cnt = {`DF_GAP_W{1'b0}};
                    nxt_gap = 1'b0;
                end else if (gap_cnt != GAP_LIMIT) begin
                    nxt_cnt = gap_cnt + 1'b1;
                end else begin
                    nxt_gap = 1'b1;
                end
            end

            assign nxt_bit_valid[g]   = nxt_valid;
            assign nxt_bit_data[g]    = nxt_data;
            assign nxt_gap_overrun[g] = nxt_gap;
            assign nxt_gap_cnt[`DF_GAP_W*g+`DF_GAP_W-1:`DF_GAP_W*g] = nxt_cnt;

            assign nxt_bandwidth[2*g+1:2*g] = bw_code(eff_lo, eff_hi);
            assign nxt_path[g]              = eff_path;
            // zero in bit 4 enables fast recovery
            assign nxt_fast_recovery[g] = hw_mode | ~ctrl[`DF_BIT_APS_DIS];
            assign nxt_filter_reset[g]  = ~hw_mode & ctrl[`DF_BIT_RESET];
            // Sticky: a lost bit is a hard fault, cleared by reset only
            assign nxt_overflow[g] = o_overflow[g] | (take_bit & ~buf_in_ready);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Captured stream flops
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_bit_valid <= 3'h0;
            o_bit_data  <= 3'h0;
        end else begin
            o_bit_valid <= nxt_bit_valid;
            o_bit_data  <= nxt_bit_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Effective configuration flops
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_bandwidth                   <= {`DF_NUM_CH{`DF_BW_NARROW}};
            o_attenuator_in_transmit_path <= 3'h0;
            o_fast_recovery_en            <= 3'h7;
            o_filter_reset                <= 3'h0;
        end else begin
            o_bandwidth                   <= nxt_bandwidth;
            o_attenuator_in_transmit_path <= nxt_path;
            o_fast_recovery_en            <= nxt_fast_recovery;
            o_filter_reset                <= nxt_filter_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Health flags and gap counters
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_gap_overrun <= 3'h0;
            o_overflow    <= 3'h0;
            gap_cnt_ff    <= {3*`DF_GAP_W{1'b0}};
        end else begin
            o_gap_overrun <= nxt_gap_overrun;
            o_overflow    <= nxt_overflow;
            gap_cnt_ff    <= nxt_gap_cnt;
        end
    end
endmodule
`default_nettype wire

//--- verif/desync_mapper_model.sv
// Mapper side of one channel: gapped clock and data.
// Assumes the receiver samples data on the rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module desync_mapper_model (
    // Link pins
    output var logic o_clk,
    output var logic o_data
);
    logic busy = 1'b0;
    initial begin
        o_clk = 1'b0;
        o_data = 1'b0;
    end
    // filler bits move data, never the clock
    always #80 if (!busy) o_data = ~o_data;
    // data steady around the rising edge
    task automatic send(input logic b);
        busy = 1'b1;
        o_data = b;
        #40 o_clk = 1'b1;
        #80 o_clk = 1'b0;
        #40 busy = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- verif/desync_filter_config_assertions.sv
// Checker on the configuration block's ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module desync_filter_config_assertions (
    // Clock, reset, register port
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    // Straps, stream and settings
    input wire logic       i_hw_mode,
    input wire logic [2:0] i_bandwidth_select_low,
    input wire logic [2:0] i_bandwidth_select_high,
    input wire logic [2:0] i_attenuator_path_select,
    input wire logic [2:0] o_bit_valid,
    input wire logic [2:0] o_bit_data,
    input wire logic [2:0] i_bit_ready,
    input wire logic [5:0] o_bandwidth,
    input wire logic [2:0] o_attenuator_in_transmit_path,
    input wire logic [2:0] o_fast_recovery_en,
    input wire logic [2:0] o_filter_reset
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    ////////////////////////////////////////
    // Strap mode held off long enough for the synchronizer
    sequence s_host_wr0;
        (!i_hw_mode) [*5] ##0 (i_wr && i_addr == 8'h07);
    endsequence
    sequence s_hw_held;
        i_hw_mode [*5];
    endsequence
    property p_rdata_idle;
        !$past(i_rd) |-> o_rdata == 8'h00;
    endproperty
    property p_ro_bits;
        o_rdata[7:5] == 3'h0;
    endproperty
    property p_host_narrow;
        s_host_wr0 ##0 (i_wdata[0] && !i_wdata[2]) |-> ##2 o_bandwidth[1:0] == 2'h1;
    endproperty
    property p_host_path;
        s_host_wr0 |-> ##2 o_attenuator_in_transmit_path[0] == $past(i_wdata[1], 2);
    endproperty
    property p_host_fast;
        s_host_wr0 |-> ##2 o_fast_recovery_en[0] == !$past(i_wdata[4], 2);
    endproperty
    property p_hw_narrow;
        (i_hw_mode && i_bandwidth_select_low[0] && !i_bandwidth_select_high[0]) [*5] |-> o_bandwidth[1:0] == 2'h1;
    endproperty
    property p_hw_path;
        (i_hw_mode && $stable(i_attenuator_path_select)) [*5] |-> o_attenuator_in_transmit_path == i_attenuator_path_select;
    endproperty
    property p_hw_fixed;
        s_hw_held |-> o_fast_recovery_en == 3'h7 && o_filter_reset == 3'h0;
    endproperty
    property p_bit_hold;
        o_bit_valid[0] && !i_bit_ready[0] |=> o_bit_valid[0] && $stable(o_bit_data[0]);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its slot");
    a_ro_bits: assert property (p_ro_bits)
        else $error("unused bits read nonzero");
    a_host_narrow: assert property (p_host_narrow)
        else $error("host narrow bandwidth not applied");
    a_host_path: assert property (p_host_path)
        else $error("host path bit not applied");
    a_host_fast: assert property (p_host_fast)
        else $error("fast recovery not following bit 4");
    a_hw_narrow: assert property (p_hw_narrow)
        else $error("strap narrow bandwidth not applied");
    a_hw_path: assert property (p_hw_path)
        else $error("strap path not applied");
    a_hw_fixed: assert property (p_hw_fixed)
        else $error("strap mode recovery or reset wrong");
    a_bit_hold: assert property (p_bit_hold)
        else $error("captured bit dropped while stalled");
endmodule
bind desync_filter_config desync_filter_config_assertions u_chk (.*);
`default_nettype wire

//--- verif/desync_filter_config_tb_top.sv
// Bench: register access, mapper stream and strap mode.
// Assumes the mapper model and checker compile first.
`timescale 1ns/10ps
`default_nettype none
module desync_filter_config_tb_top;
    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, hw = 1'b0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
    logic [2:0] bl = 3'h0, bh = 3'h0, ps = 3'h0, rdy = 3'h7;
    wire  [2:0] tck, tdt;
    logic [2:0] bv, bd, ptx, fr, frs, gap, ovf;
    logic [5:0] bw;
    logic [7:0] ofs[3] = '{8'h07, 8'h0F, 8'h17};
    logic       got[$], exp[$];
    int         err_total = 0, tests_run = 0;
    always #4 clk = ~clk;
    desync_filter_config DUT (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdat), .i_hw_mode(hw), .i_bandwidth_select_low(bl), .i_bandwidth_select_high(bh),
        .i_attenuator_path_select(ps), .i_tx_clock_in(tck), .i_tx_data_in(tdt), .o_bit_valid(bv),
        .o_bit_data(bd), .i_bit_ready(rdy), .o_bandwidth(bw), .o_attenuator_in_transmit_path(ptx),
        .o_fast_recovery_en(fr), .o_filter_reset(frs), .o_gap_overrun(gap), .o_overflow(ovf));
    desync_mapper_model mp[2:0] (.o_clk(tck), .o_data(tdt));
    always @(posedge clk) if (bv[0] & rdy[0]) got.push_back(bd[0]);
    ////////////////////////////////////////
    task automatic final_report;
        $display("errors %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) {addr, wd, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 1'b0;
        #1 chk(rdat, e);
    endtask
    task automatic settle;
        repeat (6) @(posedge clk);
        #1;
    endtask
    // Sends bits on channel 0; keep marks how many should survive
    task automatic burst(input logic [7:0] v, input int n, input int keep);
        for (int i = 0; i < n; i++) begin
            if (i < keep) exp.push_back(v[i]);
            mp[0].send(v[i]);
        end
    endtask
    task automatic drain;
        for (int i = 0; i < 400 && got.size() < exp.size(); i++) @(posedge clk);
        if (got.size() < exp.size()) begin
            $display("mismatch %0t stream drain timed out", $time);
            err_total++;
            final_report;
        end
        foreach (exp[i]) chk({7'h0, got[i]}, {7'h0, exp[i]});
    endtask
    initial begin
        #500000 $display("mismatch %0t run timed out", $time);
        err_total++;
        final_report;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        settle;
        chk({2'h0, bw}, 8'h15);
        chk({2'h0, fr, ptx}, 8'h38);
        foreach (ofs[i]) begin
            rd_reg(ofs[i], 8'h01);
            wr_reg(ofs[i], 8'hFF);
            rd_reg(ofs[i], 8'h1F);
        end
        wr_reg(8'h08, 8'h1F);
        rd_reg(8'h08, 8'h00);
        settle;
        chk({2'h0, bw}, 8'h3F);
        chk({2'h0, fr, frs}, 8'h07);
        foreach (ofs[i]) wr_reg(ofs[i], 8'h13);
        settle;
        chk({2'h0, bw}, 8'h15);
        chk({2'h0, fr, ptx}, 8'h07);
        foreach (ofs[i]) wr_reg(ofs[i], 8'h03);
        settle;
        chk({5'h0, fr}, 8'h07);
        burst(8'h4B, 8, 8);
        #(59 * 160) chk({7'h0, gap[0]}, 8'h00);
        burst(8'h01, 1, 1);
        #(70 * 160) chk({7'h0, gap[0]}, 8'h01);
        burst(8'h00, 1, 1);
        settle;
        chk({7'h0, gap[0]}, 8'h00);
        drain;
        @(posedge clk) rdy <= 3'h6;
        burst(8'h15, 5, 3);
        chk({5'h0, ovf}, 8'h01);
        @(posedge clk) rdy <= 3'h7;
        drain;
        wr_reg(8'h07, 8'h1E);
        settle;
        chk({5'h0, frs}, 8'h01);
        @(posedge clk) {hw, bl, bh, ps} <= {1'b1, 3'h1, 3'h2, 3'h4};
        wr_reg(8'h0F, 8'h10);
        settle;
        chk({2'h0, bw}, 8'h09);
        chk({2'h0, ptx, frs}, 8'h20);
        chk({5'h0, fr}, 8'h07);
        rd_reg(8'h07, 8'h1E);
        final_report;
    end
endmodule
`default_nettype wire
